/* File: src/cpt_pkg.sv */
package cpt_pkg;

    localparam int CPT_COUNT_W    = 16;
    localparam int CPT_REG_W      = 24;
    localparam int CPT_ADDR_W     = 8;
    localparam int CPT_NUM_REGS   = 10;
    localparam int CPT_NUM_PHASES = 5;

    typedef logic [CPT_COUNT_W-1:0] cpt_count_t;

    // Register addresses on the serial register port
    localparam logic [CPT_ADDR_W-1:0] CPT_ADDR_LED1_CONV_START     = 8'h11;
    localparam logic [CPT_ADDR_W-1:0] CPT_ADDR_LED1_CONV_END       = 8'h12;
    localparam logic [CPT_ADDR_W-1:0] CPT_ADDR_LED1_AMB_CONV_START = 8'h13;
    localparam logic [CPT_ADDR_W-1:0] CPT_ADDR_LED1_AMB_CONV_END   = 8'h14;
    localparam logic [CPT_ADDR_W-1:0] CPT_ADDR_ADC_RESET0_START    = 8'h15;
    localparam logic [CPT_ADDR_W-1:0] CPT_ADDR_ADC_RESET0_END      = 8'h16;
    localparam logic [CPT_ADDR_W-1:0] CPT_ADDR_ADC_RESET1_START    = 8'h17;
    localparam logic [CPT_ADDR_W-1:0] CPT_ADDR_ADC_RESET1_END      = 8'h18;
    localparam logic [CPT_ADDR_W-1:0] CPT_ADDR_ADC_RESET2_START    = 8'h19;
    localparam logic [CPT_ADDR_W-1:0] CPT_ADDR_ADC_RESET2_END      = 8'h1A;

    // Count field position inside a 24-bit register
    localparam int CPT_COUNT_LSB = 0;
    localparam int CPT_COUNT_MSB = 15;

    localparam cpt_count_t CPT_COUNT_RESET = 16'h0000;
    localparam logic [CPT_REG_W-1:0] CPT_RDATA_RESET = 24'h000000;

    // Phase indices; start count of phase p sits at register 2p, end at 2p+1
    localparam int CPT_PH_LED1_CONV     = 0;
    localparam int CPT_PH_LED1_AMB_CONV = 1;
    localparam int CPT_PH_ADC_RESET0    = 2;
    localparam int CPT_PH_ADC_RESET1    = 3;
    localparam int CPT_PH_ADC_RESET2    = 4;

    // Timing clock derived from the system clock
    localparam int CPT_TIMING_CLK_PERIOD_NS = 250;
    localparam int CPT_SYS_CLK_PERIOD_NS    = 10;
    localparam int CPT_TICK_CYCLES          = CPT_TIMING_CLK_PERIOD_NS / CPT_SYS_CLK_PERIOD_NS;

endpackage : cpt_pkg

/* File: src/cpt_conversion_phase_timer.sv */
// How it works
// R01: LED1 conversion starts when period counter reaches its start count.
// R02: LED1 conversion ends when period counter reaches its end count.
// R03: LED1 ambient conversion starts when counter equals its start count.
// R04: LED1 ambient conversion ends when counter equals its end count.
// R05: ADC reset 0 starts at its start count.
// R06: ADC reset 0 ends at its end count.
// R07: ADC reset 1 starts at its start count.
// R08: ADC reset 1 ends at its end count.
// R09: ADC reset 2 starts at its start count.
// R10: ADC reset 2 ends at its end count.
// R11: Host keeps upper eight bits zero; only low 16 bits hold the count.
// R12: All count registers read zero after reset until written.
// R13: Host programs the period between 800 and 64000 timing cycles.
// R14: Counter and comparisons run only while the timer enable is set.
// R15: Counter steps once per 4 MHz tick, wraps at period; phases span start to end.
`timescale 1ns/1ps
`default_nettype none

module cpt_conversion_phase_timer
    import cpt_pkg::*;
#(
    parameter int TICK_DIV = CPT_TICK_CYCLES
) (
    input  wire logic                  sys_clk,
    input  wire logic                  sys_rst,
    input  wire logic                  regWrEn,
    input  wire logic [CPT_ADDR_W-1:0] regAddr,
    input  wire logic [CPT_REG_W-1:0]  regWrData,
    output logic      [CPT_REG_W-1:0]  regRdData,
    input  wire logic                  timerRunEnable,
    input  wire logic [CPT_COUNT_W-1:0] pulseRepetitionPeriod,
    output logic      [CPT_COUNT_W-1:0] periodCountValue,
    output logic                       led1Conv,
    output logic                       led1AmbientConv,
    output logic                       adcReset0,
    output logic                       adcReset1,
    output logic                       adcReset2
);

    localparam int TICK_W = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;

    function automatic logic inWindow(input cpt_count_t cnt,
                                      input cpt_count_t startCnt,
                                      input cpt_count_t endCnt);
        inWindow = (cnt >= startCnt) && (cnt < endCnt);
    endfunction : inWindow

    ////////////////////////////////////////////////////////////////////////////////
    // Register file

    cpt_count_t                 countQ [CPT_NUM_REGS];
    logic                       wroteQ;
    logic      [CPT_REG_W-1:0]  rdDataQ;
    wire logic                  regHit;
    wire logic [CPT_ADDR_W-1:0] regOffs;
    wire logic [3:0]            regIdx;
    wire logic                  regWrHit;
    wire logic [CPT_REG_W-1:0]  rdDataD;

    assign regHit   = (regAddr >= CPT_ADDR_LED1_CONV_START) &&
                      (regAddr <= CPT_ADDR_ADC_RESET2_END);
    assign regOffs  = regAddr - CPT_ADDR_LED1_CONV_START;
    assign regIdx   = regOffs[3:0];
    assign regWrHit = regWrEn && regHit;
    // Upper byte is not stored, so it always reads back as zero
    assign rdDataD  = regHit ? {8'h00, countQ[regIdx]} : CPT_RDATA_RESET; // [R11]

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < CPT_NUM_REGS; i++) begin
                countQ[i] <= CPT_COUNT_RESET; // [R12]
            end
        end else if (regWrHit) begin
            countQ[regIdx] <= regWrData[CPT_COUNT_MSB:CPT_COUNT_LSB]; // [R11]
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdDataQ <= CPT_RDATA_RESET;
            wroteQ  <= 1'b0;
        end else begin
            rdDataQ <= rdDataD;
            wroteQ  <= wroteQ | regWrHit;
        end
    end

    assign regRdData = rdDataQ;

    ////////////////////////////////////////////////////////////////////////////////
    // Timing tick and period counter

    logic      [TICK_W-1:0]     tickCntQ;
    logic      [TICK_W-1:0]     tickCntD;
    cpt_count_t                 periodCntQ;
    cpt_count_t                 periodCntD;
    wire logic                  tick;
    wire logic                  wrapNow;

    // Divider is held in reset while disabled, which stands in for stopped clocks
    assign tick     = timerRunEnable && (tickCntQ == TICK_W'(TICK_DIV - 1)); // [R14]
    assign tickCntD = (!timerRunEnable || tick) ? '0 : tickCntQ + 1'b1;
    // A period below the counter value wraps at once rather than running to 65535
    assign wrapNow  = periodCntQ >= pulseRepetitionPeriod; // [R15]
    assign periodCntD = !timerRunEnable ? CPT_COUNT_RESET :
                        !tick           ? periodCntQ :
                        wrapNow         ? CPT_COUNT_RESET :
                                          periodCntQ + 1'b1; // [R15]

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tickCntQ   <= '0;
            periodCntQ <= CPT_COUNT_RESET;
        end else begin
            tickCntQ   <= tickCntD;
            periodCntQ <= periodCntD;
        end
    end

    assign periodCountValue = periodCntQ;

    ////////////////////////////////////////////////////////////////////////////////
    // Phase windows

    logic [CPT_NUM_PHASES-1:0] phaseQ;
    wire  [CPT_NUM_PHASES-1:0] phaseD;

    for (genvar p = 0; p < CPT_NUM_PHASES; p++) begin : g_phase
        // Start and end counts pair up as registers 2p and 2p+1
        assign phaseD[p] = timerRunEnable &&
                           inWindow(periodCntQ, countQ[2*p], countQ[2*p+1]); // [R01] [R03] [R05]
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            phaseQ <= '0;
        end else begin
            phaseQ <= phaseD; // [R02] [R04] [R06] [R07] [R08] [R09] [R10]
        end
    end

    assign led1Conv        = phaseQ[CPT_PH_LED1_CONV];
    assign led1AmbientConv = phaseQ[CPT_PH_LED1_AMB_CONV];
    assign adcReset0       = phaseQ[CPT_PH_ADC_RESET0];
    assign adcReset1       = phaseQ[CPT_PH_ADC_RESET1];
    assign adcReset2       = phaseQ[CPT_PH_ADC_RESET2];

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cbMain @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence sqWrapTick;
        tick && wrapNow;
    endsequence

    sequence sqStepTick;
        tick && !wrapNow;
    endsequence

    sequence sqIdleTick;
        timerRunEnable && !tick;
    endsequence

    sequence sqRegWrite;
        regWrHit;
    endsequence

    sequence sqRegRead;
        regHit;
    endsequence

    AST_LED1_CONV_START: assert property ( // [R01]
        (timerRunEnable && periodCntQ == countQ[0] && countQ[0] < countQ[1]) |=> led1Conv)
        else $error("LED1 conversion did not start at its start count");
    AST_LED1_CONV_END: assert property ( // [R02]
        (periodCntQ == countQ[1]) |=> !led1Conv)
        else $error("LED1 conversion did not end at its end count");
    AST_LED1_AMB_START: assert property ( // [R03]
        (timerRunEnable && periodCntQ == countQ[2] && countQ[2] < countQ[3])
        |=> led1AmbientConv)
        else $error("LED1 ambient conversion did not start at its start count");
    AST_LED1_AMB_END: assert property ( // [R04]
        (periodCntQ == countQ[3]) |=> !led1AmbientConv)
        else $error("LED1 ambient conversion did not end at its end count");
    AST_ADC_RST0_START: assert property ( // [R05]
        (timerRunEnable && periodCntQ == countQ[4] && countQ[4] < countQ[5]) |=> adcReset0)
        else $error("ADC reset 0 did not start at its start count");
    AST_ADC_RST0_END: assert property ( // [R06]
        (periodCntQ == countQ[5]) |=> !adcReset0)
        else $error("ADC reset 0 did not end at its end count");
    AST_ADC_RST1_START: assert property ( // [R07]
        (timerRunEnable && periodCntQ == countQ[6] && countQ[6] < countQ[7]) |=> adcReset1)
        else $error("ADC reset 1 did not start at its start count");
    AST_ADC_RST1_END: assert property ( // [R08]
        (periodCntQ == countQ[7]) |=> !adcReset1)
        else $error("ADC reset 1 did not end at its end count");
    AST_ADC_RST2_START: assert property ( // [R09]
        (timerRunEnable && periodCntQ == countQ[8] && countQ[8] < countQ[9]) |=> adcReset2)
        else $error("ADC reset 2 did not start at its start count");
    AST_ADC_RST2_END: assert property ( // [R10]
        (periodCntQ == countQ[9]) |=> !adcReset2)
        else $error("ADC reset 2 did not end at its end count");
    AST_UPPER_BYTE_ZERO: assert property ( // [R11]
        regRdData[CPT_REG_W-1:CPT_COUNT_MSB+1] == 8'h00)
        else $error("Upper byte of a count register read back nonzero");
    AST_READ_ZERO_UNTIL_WRITE: assert property ( // [R12]
        (!wroteQ && !regWrHit && regHit) |=> regRdData == CPT_RDATA_RESET)
        else $error("Count register read nonzero before any write");
    AST_DISABLED_STOPS: assert property ( // [R14]
        !timerRunEnable |=> (periodCountValue == CPT_COUNT_RESET && phaseQ == '0))
        else $error("Timer ran while disabled");
    AST_WRAP: assert property ( // [R15]
        sqWrapTick |=> periodCountValue == CPT_COUNT_RESET)
        else $error("Period counter did not wrap at the period count");
    AST_STEP: assert property ( // [R15]
        sqStepTick |=> periodCountValue == $past(periodCntQ) + 16'h0001)
        else $error("Period counter did not step by one on a tick");
    AST_TICK_SPACING: assert property ( // [R15]
        tick |=> !tick [*8])
        else $error("Timing ticks came too close together");

    // Phases follow the window on every cycle, so a late edge or a glitch is caught too
    AST_LED1_CONV_INSIDE: assert property ( // [R01]
        (timerRunEnable && inWindow(periodCntQ, countQ[0], countQ[1])) |=> led1Conv)
        else $error("LED1 conversion low inside its window");

    AST_LED1_CONV_OUTSIDE: assert property ( // [R02]
        !(timerRunEnable && inWindow(periodCntQ, countQ[0], countQ[1])) |=> !led1Conv)
        else $error("LED1 conversion high outside its window");

    AST_LED1_CONV_EMPTY: assert property ( // [R02]
        (countQ[0] >= countQ[1]) |=> !led1Conv)
        else $error("LED1 conversion high with an empty window");

    AST_LED1_AMB_INSIDE: assert property ( // [R03]
        (timerRunEnable && inWindow(periodCntQ, countQ[2], countQ[3])) |=> led1AmbientConv)
        else $error("LED1 ambient conversion low inside its window");

    AST_LED1_AMB_OUTSIDE: assert property ( // [R04]
        !(timerRunEnable && inWindow(periodCntQ, countQ[2], countQ[3])) |=> !led1AmbientConv)
        else $error("LED1 ambient conversion high outside its window");

    AST_LED1_AMB_EMPTY: assert property ( // [R04]
        (countQ[2] >= countQ[3]) |=> !led1AmbientConv)
        else $error("LED1 ambient conversion high with an empty window");

    AST_ADC_RST0_INSIDE: assert property ( // [R05]
        (timerRunEnable && inWindow(periodCntQ, countQ[4], countQ[5])) |=> adcReset0)
        else $error("ADC reset 0 low inside its window");

    AST_ADC_RST0_OUTSIDE: assert property ( // [R06]
        !(timerRunEnable && inWindow(periodCntQ, countQ[4], countQ[5])) |=> !adcReset0)
        else $error("ADC reset 0 high outside its window");

    AST_ADC_RST0_EMPTY: assert property ( // [R06]
        (countQ[4] >= countQ[5]) |=> !adcReset0)
        else $error("ADC reset 0 high with an empty window");

    AST_ADC_RST1_INSIDE: assert property ( // [R07]
        (timerRunEnable && inWindow(periodCntQ, countQ[6], countQ[7])) |=> adcReset1)
        else $error("ADC reset 1 low inside its window");

    AST_ADC_RST1_OUTSIDE: assert property ( // [R08]
        !(timerRunEnable && inWindow(periodCntQ, countQ[6], countQ[7])) |=> !adcReset1)
        else $error("ADC reset 1 high outside its window");

    AST_ADC_RST1_EMPTY: assert property ( // [R08]
        (countQ[6] >= countQ[7]) |=> !adcReset1)
        else $error("ADC reset 1 high with an empty window");

    AST_ADC_RST2_INSIDE: assert property ( // [R09]
        (timerRunEnable && inWindow(periodCntQ, countQ[8], countQ[9])) |=> adcReset2)
        else $error("ADC reset 2 low inside its window");

    AST_ADC_RST2_OUTSIDE: assert property ( // [R10]
        !(timerRunEnable && inWindow(periodCntQ, countQ[8], countQ[9])) |=> !adcReset2)
        else $error("ADC reset 2 high outside its window");

    AST_ADC_RST2_EMPTY: assert property ( // [R10]
        (countQ[8] >= countQ[9]) |=> !adcReset2)
        else $error("ADC reset 2 high with an empty window");

    // Register port and divider housekeeping
    AST_COUNT_HOLDS: assert property ( // [R15]
        sqIdleTick |=> periodCountValue == $past(periodCntQ))
        else $error("Period counter moved between ticks");

    AST_WRITE_LANDS: assert property ( // [R11]
        sqRegWrite |=> countQ[$past(regIdx)] == $past(regWrData[CPT_COUNT_MSB:CPT_COUNT_LSB]))
        else $error("Register write did not store the low count bits");

    AST_READ_DATA: assert property ( // [R11]
        sqRegRead |=> regRdData == {8'h00, $past(countQ[regIdx])})
        else $error("Register read did not return the stored count");

    AST_UNMAPPED_ZERO: assert property ( // [R12]
        !regHit |=> regRdData == CPT_RDATA_RESET)
        else $error("Unmapped address read back nonzero");

    AST_NO_TICK_DISABLED: assert property ( // [R14]
        !timerRunEnable |-> !tick)
        else $error("Timing tick while the timer is disabled");

    AST_DIV_BOUND: assert property ( // [R15]
        int'(tickCntQ) < TICK_DIV)
        else $error("Tick divider ran past its terminal count");

    AST_WROTE_STICKY: assert property ( // [R12]
        wroteQ |=> wroteQ)
        else $error("Written flag cleared without reset");

endmodule : cpt_conversion_phase_timer

`default_nettype wire

/* File: dv/cpt_adc_model.sv */
`timescale 1ns/1ps
`default_nettype none

module cpt_adc_model (
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        phase,
    output logic      [15:0] widthCycles
);
    logic [15:0] runLen_q;

    // Latch the length of a window only once it has closed, so a reader never sees a partial length
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            runLen_q    <= 16'h0000;
            widthCycles <= 16'h0000;
        end else if (phase) begin
            runLen_q <= runLen_q + 16'h0001;
        end else if (runLen_q != 16'h0000) begin
            widthCycles <= runLen_q;
            runLen_q    <= 16'h0000;
        end
    end
endmodule : cpt_adc_model

`default_nettype wire

/* File: dv/test_conversion_phase_timer.sv */
`timescale 1ns/1ps
`default_nettype none

module test_conversion_phase_timer;
    import cpt_pkg::*;
    localparam int         DIV = 9;
    localparam cpt_count_t PER = 16'h0320;
    logic                   sys_clk, sys_rst, regWrEn, timerRunEnable, prevEn;
    logic [CPT_ADDR_W-1:0]  regAddr;
    logic [CPT_REG_W-1:0]   regWrData, regRdData, rd;
    logic [CPT_COUNT_W-1:0] pulseRepetitionPeriod, periodCountValue;
    logic [4:0]             phaseVec, expPh;
    logic [15:0]            widths [CPT_NUM_PHASES];
    cpt_count_t             startCnt [CPT_NUM_PHASES], endCnt [CPT_NUM_PHASES], prevCnt;
    int                     bad_count, tests_run, gap;

    cpt_conversion_phase_timer #(.TICK_DIV(DIV)) dut_u (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .regWrEn(regWrEn), .regAddr(regAddr),
        .regWrData(regWrData), .regRdData(regRdData), .timerRunEnable(timerRunEnable),
        .pulseRepetitionPeriod(pulseRepetitionPeriod), .periodCountValue(periodCountValue),
        .led1Conv(phaseVec[0]), .led1AmbientConv(phaseVec[1]), .adcReset0(phaseVec[2]),
        .adcReset1(phaseVec[3]), .adcReset2(phaseVec[4]));

    for (genvar p = 0; p < CPT_NUM_PHASES; p++) begin : g_adc
        cpt_adc_model adc_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .phase(phaseVec[p]),
                             .widthCycles(widths[p]));
    end

    always #5 sys_clk = ~sys_clk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic reg_write(input logic [7:0] a, input logic [23:0] d);
        @(negedge sys_clk);
        regWrEn   = 1'b1;
        regAddr   = a;
        regWrData = d;
        @(negedge sys_clk);
        regWrEn = 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, output logic [23:0] d);
        @(negedge sys_clk);
        regAddr = a;
        @(negedge sys_clk);
        d = regRdData;
    endtask : reg_read

    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        sys_rst = 1'b1;
        regWrEn = 1'b0;
        regAddr = 8'h00;
        regWrData = 24'h000000;
        timerRunEnable = 1'b0;
        pulseRepetitionPeriod = PER;
        bad_count = 0;
        tests_run = 0;
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk);
        sys_rst = 1'b0;
        // Last pass reads the first unmapped address above the group
        for (int r = 0; r <= CPT_NUM_REGS; r++) begin
            reg_read(CPT_ADDR_LED1_CONV_START + 8'(r), rd);
            check("reset value", rd, CPT_RDATA_RESET);
        end
        // Phase 0 starts at the period origin; the last phase has an empty window
        for (int p = 0; p < CPT_NUM_PHASES; p++) begin
            startCnt[p] = (p == 0) ? 16'h0000 : 16'(4 + 10 * p);
            endCnt[p] = (p == CPT_PH_ADC_RESET2) ? startCnt[p] : 16'(6 + 11 * p);
            reg_write(CPT_ADDR_LED1_CONV_START + 8'(2 * p), {8'h00, startCnt[p]});
            reg_write(CPT_ADDR_LED1_CONV_START + 8'(2 * p + 1), {8'h00, endCnt[p]});
        end
        reg_write(8'h10, 24'h00ABCD);
        for (int p = 0; p < CPT_NUM_PHASES; p++) begin
            reg_read(CPT_ADDR_LED1_CONV_START + 8'(2 * p), rd);
            check("start count", rd, {8'h00, startCnt[p]});
            reg_read(CPT_ADDR_LED1_CONV_START + 8'(2 * p + 1), rd);
            check("end count", rd, {8'h00, endCnt[p]});
        end
        reg_read(8'h10, rd);
        check("unmapped read", rd, CPT_RDATA_RESET);
        timerRunEnable = 1'b1;
        prevEn = timerRunEnable;
        prevCnt = periodCountValue;
        gap = -1;
        // Runs past the wrap so every non-empty window is seen in a second period
        repeat ((int'(PER) + 50) * DIV) begin
            @(negedge sys_clk);
            for (int p = 0; p < CPT_NUM_PHASES; p++) begin
                expPh[p] = prevEn && startCnt[p] <= prevCnt && prevCnt < endCnt[p];
            end
            check("phases", 24'(phaseVec), 24'(expPh));
            check("phases", 24'(phaseVec), 24'(expPh));
            if (periodCountValue !== prevCnt) begin
                check("count step", 24'(periodCountValue),
                      (prevCnt == PER) ? 24'h000000 : 24'(prevCnt + 16'h0001));
                if (gap > 0) begin
                    check("tick gap", 24'(gap), 24'(DIV));
                end
                gap = 0;
            end
            if (gap >= 0) begin
                gap++;
            end
            prevEn = timerRunEnable;
            prevCnt = periodCountValue;
        end
        for (int p = 0; p < CPT_NUM_PHASES; p++) begin
            check("window width", 24'(widths[p]), 24'((endCnt[p] - startCnt[p]) * DIV));
        end
        timerRunEnable = 1'b0;
        repeat (2) @(negedge sys_clk);
        check("stopped count", 24'(periodCountValue), 24'h000000);
        check("stopped phases", 24'(phaseVec), 24'h000000);
        // A second reset after the timer is stopped must clear the counts that were loaded; the ADC reset 1 end count is read back
        @(negedge sys_clk);
        sys_rst = 1'b1;
        repeat (2) @(negedge sys_clk);
        sys_rst = 1'b0;
        reg_read(CPT_ADDR_ADC_RESET1_END, rd);
        check("count after second reset", rd, CPT_RDATA_RESET);
        complete_run();
    end

    // Expected run is about 8000 cycles
    initial begin
        #(20000 * 10);
        bad_count++;
        $display("mismatch watchdog expected end of tests seen hang");
        complete_run();
    end
endmodule : test_conversion_phase_timer

`default_nettype wire
